// >>> wwd_pkg.sv
package wwd_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] WWD_OFS_RESTART_CONTROL = 8'h00;
   localparam logic [7:0] WWD_OFS_WATCHDOG_CONFIG = 8'h04;
   localparam logic [7:0] WWD_OFS_FAULT_FLAGS = 8'h08;
   localparam logic [31:0] WWD_CONFIG_RESET = 32'h3fff2fff;
   localparam logic [7:0] WWD_EXPECTED_KEY = 8'ha5;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int WWD_KEY_LSB = 24;
   localparam int WWD_KEY_MSB = 31;
   localparam int WWD_RESTART_BIT = 0;
   localparam int WWD_RELOAD_LSB = 0;
   localparam int WWD_RELOAD_MSB = 11;
   localparam int WWD_FIEN_BIT = 12;
   localparam int WWD_RSTEN_BIT = 13;
   localparam int WWD_SCOPE_BIT = 14;
   localparam int WWD_DIS_BIT = 15;
   localparam int WWD_DELTA_LSB = 16;
   localparam int WWD_DELTA_MSB = 27;
   localparam int WWD_DBG_HALT_BIT = 28;
   localparam int WWD_IDLE_HALT_BIT = 29;
   localparam int WWD_UNF_BIT = 0;
   localparam int WWD_ERR_BIT = 1;

   // ****************************************
   // Counter and prescaler
   // ****************************************
   localparam int WWD_CNT_W = 12;
   localparam int WWD_DIV = 128;
   localparam int WWD_DIV_W = 7;
   localparam logic [WWD_DIV_W-1:0] WWD_DIV_LAST = WWD_DIV_W'(WWD_DIV - 1);
   localparam logic [WWD_CNT_W-1:0] WWD_CNT_ZERO = 12'h000;
   localparam logic [WWD_DIV_W-1:0] WWD_DIV_ZERO = 7'h00;
endpackage

// >>> wwd_prescaler.sv
`timescale 1ns/1ps
module wwd_prescaler
   import wwd_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic slck_en,
   input wire logic run,
   input wire logic restart,
   output logic tick
);
   typedef struct packed {
      logic [WWD_DIV_W-1:0] cnt;
      logic tick;
   } wwd_div_t;

   wwd_div_t div_r;
   wwd_div_t div_nxt;

   // ****************************************
   // Slow clock divided by 128
   // ****************************************
   always_comb begin
      div_nxt = div_r;
      div_nxt.tick = 1'b0;
      if (restart) begin
         div_nxt.cnt = WWD_DIV_ZERO;
      end else if (run && slck_en) begin
         div_nxt.cnt = div_r.cnt + 7'h01;
         div_nxt.tick = (div_r.cnt == WWD_DIV_LAST);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_r <= '0;
      end else begin
         div_r <= div_nxt;
      end
   end

   assign tick = div_r.tick;
endmodule // wwd_prescaler

// >>> wwd_watchdog.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module wwd_watchdog
   import wwd_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic slck_en,
   input wire logic cpu_debug,
   input wire logic sys_idle,
   output logic wdt_irq,
   output logic wdt_fault,
   output logic wdt_proc_only
);
   import wwd_pkg::*;

   typedef struct packed {
      logic [31:0] cfg;
      logic locked;
      logic [WWD_CNT_W-1:0] cnt;
      logic unf;
      logic err;
      logic irq;
      logic fault;
      logic proc_only;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } wwd_state_t;

   wwd_state_t st_r;
   wwd_state_t st_nxt;

   logic tick;
   logic halt;
   logic setup;
   logic access;
   logic wr_ctrl;
   logic key_ok;
   logic restart_req;
   logic cfg_wr;
   logic rd_flags;
   logic in_window;
   logic reload;
   logic dis;

   // ****************************************
   // Bus decode
   // ****************************************
   // No wait state: read data is staged in setup so prdata leaves a flop
   assign setup = psel && !penable;
   assign access = psel && penable && st_r.pready;
   assign wr_ctrl = access && pwrite && (paddr == WWD_OFS_RESTART_CONTROL);
   assign key_ok = (pwdata[WWD_KEY_MSB:WWD_KEY_LSB] == WWD_EXPECTED_KEY);
   assign restart_req = wr_ctrl && key_ok && pwdata[WWD_RESTART_BIT];
   assign cfg_wr = access && pwrite && (paddr == WWD_OFS_WATCHDOG_CONFIG) && !st_r.locked;
   assign rd_flags = access && !pwrite && (paddr == WWD_OFS_FAULT_FLAGS);
   assign in_window = (st_r.cnt <= st_r.cfg[WWD_DELTA_MSB:WWD_DELTA_LSB]);
   assign dis = st_r.cfg[WWD_DIS_BIT];
   assign halt = (st_r.cfg[WWD_DBG_HALT_BIT] && cpu_debug)
      || (st_r.cfg[WWD_IDLE_HALT_BIT] && sys_idle);
   assign reload = cfg_wr || (restart_req && in_window);

   // ****************************************
   // Prescaler
   // ****************************************
   // Prescaler freezes too, so a halt does not shorten the next step
   wwd_prescaler u_prescaler (
      .clk(clk),
      .sys_rst(sys_rst),
      .slck_en(slck_en),
      .run(!halt && !dis),
      .restart(reload),
      .tick(tick)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      if (setup) begin
         st_nxt.pready = 1'b1;
         unique case (paddr)
            WWD_OFS_WATCHDOG_CONFIG: begin
               st_nxt.prdata = st_r.cfg;
            end
            WWD_OFS_FAULT_FLAGS: begin
               st_nxt.prdata = '0;
               st_nxt.prdata[WWD_UNF_BIT] = st_r.unf;
               st_nxt.prdata[WWD_ERR_BIT] = st_r.err;
            end
            WWD_OFS_RESTART_CONTROL: begin
               st_nxt.prdata = '0;
            end
            default: begin
               st_nxt.prdata = '0;
               st_nxt.pslverr = 1'b1;
            end
         endcase
      end
      // Clear first so a same-cycle event below wins over the read
      if (rd_flags) begin
         st_nxt.unf = 1'b0;
         st_nxt.err = 1'b0;
      end
      if (cfg_wr) begin
         st_nxt.cfg = pwdata;
         st_nxt.locked = 1'b1;
         st_nxt.cnt = pwdata[WWD_RELOAD_MSB:WWD_RELOAD_LSB];
      end else if (restart_req) begin
         if (in_window) begin
            st_nxt.cnt = st_r.cfg[WWD_RELOAD_MSB:WWD_RELOAD_LSB];
         end else begin
            st_nxt.err = 1'b1;
         end
      end else if (tick && !dis) begin
         if (st_r.cnt == WWD_CNT_ZERO) begin
            st_nxt.unf = 1'b1;
            st_nxt.cnt = st_r.cfg[WWD_RELOAD_MSB:WWD_RELOAD_LSB];
         end else begin
            st_nxt.cnt = st_r.cnt - 12'h001;
         end
      end
      // Outputs track the next flags so they stay a pure function of them
      st_nxt.irq = st_nxt.cfg[WWD_FIEN_BIT] && (st_nxt.unf || st_nxt.err);
      st_nxt.fault = st_nxt.cfg[WWD_RSTEN_BIT] && (st_nxt.unf || st_nxt.err);
      st_nxt.proc_only = st_nxt.fault && st_nxt.cfg[WWD_SCOPE_BIT];
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
         st_r.cfg <= WWD_CONFIG_RESET;
         st_r.cnt <= WWD_CONFIG_RESET[WWD_RELOAD_MSB:WWD_RELOAD_LSB];
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign wdt_irq = st_r.irq;
   assign wdt_fault = st_r.fault;
   assign wdt_proc_only = st_r.proc_only;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   property p_restart_reload;
      restart_req && in_window && !cfg_wr |=> st_r.cnt == $past(st_r.cfg[11:0]);
   endproperty
   a_restart_reload: assert property (p_restart_reload) else $error("Restart did not reload");

   property p_bad_key;
      wr_ctrl && !key_ok && !tick |=> st_r.cnt == $past(st_r.cnt) && st_r.err == $past(st_r.err);
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("Bad key write had effect");

   property p_cfg_once;
      st_r.locked |=> st_r.cfg == $past(st_r.cfg) && st_r.locked;
   endproperty
   a_cfg_once: assert property (p_cfg_once) else $error("Locked config changed");

   property p_cfg_reload;
      cfg_wr |=> st_r.cnt == $past(pwdata[11:0]) && st_r.cfg == $past(pwdata);
   endproperty
   a_cfg_reload: assert property (p_cfg_reload) else $error("Config write missed reload");

   property p_irq;
      wdt_irq == (st_r.cfg[WWD_FIEN_BIT] && (st_r.unf || st_r.err));
   endproperty
   a_irq: assert property (p_irq) else $error("Interrupt not gated by flags");

   property p_fault;
      wdt_fault == (st_r.cfg[WWD_RSTEN_BIT] && (st_r.unf || st_r.err));
   endproperty
   a_fault: assert property (p_fault) else $error("Fault not gated by flags");

   property p_scope;
      wdt_proc_only |-> wdt_fault && st_r.cfg[WWD_SCOPE_BIT];
   endproperty
   a_scope: assert property (p_scope) else $error("Scope output without fault");

   property p_disabled_frozen;
      dis && !cfg_wr && !restart_req |=> st_r.cnt == $past(st_r.cnt) && !$rose(st_r.unf);
   endproperty
   a_disabled_frozen: assert property (p_disabled_frozen) else $error("Disabled timer moved");

   property p_window_error;
      restart_req && !in_window |=> st_r.err && st_r.cnt == $past(st_r.cnt);
   endproperty
   a_window_error: assert property (p_window_error) else $error("Window error not raised");

   property p_halt;
      halt && !reload |=> st_r.cnt == $past(st_r.cnt);
   endproperty
   a_halt: assert property (p_halt) else $error("Counter moved while halted");

   property p_underflow;
      tick && !dis && st_r.cnt == 12'h000 && !reload |=> st_r.unf;
   endproperty
   a_underflow: assert property (p_underflow) else $error("Underflow flag not set");

   property p_read_clear;
      rd_flags && !restart_req && !tick |=> !st_r.unf && !st_r.err && !wdt_fault && !wdt_irq;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("Status read did not clear");

   property p_step;
      tick && !dis && !reload && st_r.cnt != 12'h000 |=> st_r.cnt == $past(st_r.cnt) - 12'h001;
   endproperty
   a_step: assert property (p_step) else $error("Counter did not step on tick");

   property p_ready_one;
      pready |=> !pready;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("Ready held too long");

   c_restart: cover property (restart_req && in_window);
   c_error: cover property (restart_req && !in_window);
   c_underflow: cover property ($rose(st_r.unf));
   c_cfg_write: cover property (cfg_wr);
endmodule // wwd_watchdog

// >>> test_windowed_watchdog_timer.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
   check_count++; \
   if ((got) !== (exp)) begin \
      err_total++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
   end \
end

module test_windowed_watchdog_timer;
   import wwd_pkg::*;
   // ********************
   // Stimulus and wiring
   // ********************
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic slck_en = 1'b1;
   logic cpu_debug = 1'b0;
   logic sys_idle = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic wdt_irq;
   logic wdt_fault;
   logic wdt_proc_only;
   int err_total = 0;
   int check_count = 0;
   int cyc_n = 0;

   wwd_watchdog u_wwd_watchdog (
      .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .slck_en(slck_en), .cpu_debug(cpu_debug),
      .sys_idle(sys_idle), .wdt_irq(wdt_irq), .wdt_fault(wdt_fault),
      .wdt_proc_only(wdt_proc_only)
   );

   initial begin
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
   end

   // ********************
   // Reference model
   // ********************
   // Integer model of counter and divider; the counter is checked against the design every cycle
   int m_cnt;
   int m_div;
   bit m_tick;
   bit m_lock;
   logic [31:0] m_cfg;
   always @(posedge clk or posedge sys_rst) begin
      bit acc, t, run, cfgw, rst_ok, rld;
      if (sys_rst) begin
         m_cnt = int'(WWD_CONFIG_RESET[WWD_RELOAD_MSB:WWD_RELOAD_LSB]);
         m_div = 0;
         m_tick = 1'b0;
         m_lock = 1'b0;
         m_cfg = WWD_CONFIG_RESET;
      end else begin
         `CHK("counter", m_cnt[11:0], u_wwd_watchdog.st_r.cnt)
         acc = psel && penable && pready;
         t = m_tick;
         run = !((m_cfg[WWD_DBG_HALT_BIT] && cpu_debug) || (m_cfg[WWD_IDLE_HALT_BIT] && sys_idle))
            && !m_cfg[WWD_DIS_BIT];
         cfgw = acc && pwrite && paddr == WWD_OFS_WATCHDOG_CONFIG && !m_lock;
         rst_ok = acc && pwrite && paddr == WWD_OFS_RESTART_CONTROL
            && pwdata[31:24] == WWD_EXPECTED_KEY && pwdata[0];
         rld = cfgw || (rst_ok && m_cnt <= m_cfg[27:16]);
         if (cfgw) begin
            m_cfg = pwdata;
            m_lock = 1'b1;
            m_cnt = int'(pwdata[11:0]);
         end else if (rst_ok) begin
            if (rld) begin
               m_cnt = int'(m_cfg[11:0]);
            end
         end else if (t && !m_cfg[WWD_DIS_BIT]) begin
            m_cnt = (m_cnt == 0) ? int'(m_cfg[11:0]) : m_cnt - 1;
         end
         m_tick = 1'b0;
         if (rld) begin
            m_div = 0;
         end else if (run && slck_en) begin
            m_tick = (m_div == WWD_DIV - 1);
            m_div = (m_div + 1) % WWD_DIV;
         end
      end
   end

   // ********************
   // Bus tasks
   // ********************
   // Each task starts just after an edge and ends one idle edge later,
   // so two transfers never assign the same signal in one time step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      `CHK(nm, exp, q)
      `CHK("slave error", (a > WWD_OFS_FAULT_FLAGS), e)
   endtask

   task automatic end_sim;
      $display("Mismatches %0d comparisons %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ********************
   // Main sequence
   // ********************
   initial begin
      logic [31:0] cfg;
      logic fien, rsten, scope, halted;
      int t;
      void'($urandom(32'h30c7cdf2));
      for (int i = 0; i < 8; i++) begin
         sys_rst <= 1'b1;
         cpu_debug <= 1'($urandom);
         sys_idle <= 1'($urandom);
         repeat (20) @(posedge clk);
         sys_rst <= 1'b0;
         @(posedge clk);
         rd_chk("config reset", WWD_OFS_WATCHDOG_CONFIG, WWD_CONFIG_RESET);
         rd_chk("flags reset", WWD_OFS_FAULT_FLAGS, 32'h0);
         rd_chk("control read", WWD_OFS_RESTART_CONTROL, 32'h0);
         rd_chk("unmapped", 8'h0c, 32'h0);
         fien = 1'($urandom);
         rsten = 1'($urandom);
         scope = 1'($urandom);
         // Short reload 4 and window 1 keep each pass near 1200 cycles
         cfg = {2'b00, i[2], i[1], 12'h001, i[0], scope, rsten, fien, 12'h004};
         halted = i[0] | (i[1] & cpu_debug) | (i[2] & sys_idle);
         wr(WWD_OFS_WATCHDOG_CONFIG, cfg);
         t = cyc_n;
         wr(WWD_OFS_WATCHDOG_CONFIG, ~cfg);
         rd_chk("config", WWD_OFS_WATCHDOG_CONFIG, cfg);
         wr(WWD_OFS_RESTART_CONTROL, {WWD_EXPECTED_KEY, 24'h000001});
         `CHK("irq", fien, wdt_irq)
         `CHK("fault", rsten, wdt_fault)
         `CHK("proc only", rsten & scope, wdt_proc_only)
         rd_chk("window error", WWD_OFS_FAULT_FLAGS, 32'h2);
         `CHK("outputs cleared", 1'b0, wdt_irq | wdt_fault | wdt_proc_only)
         wr(WWD_OFS_RESTART_CONTROL, 32'h5a000001);
         wr(WWD_OFS_RESTART_CONTROL, 32'ha5000000);
         rd_chk("ignored", WWD_OFS_FAULT_FLAGS, 32'h0);
         while (cyc_n < t + 450) @(posedge clk);
         wr(WWD_OFS_RESTART_CONTROL, 32'ha5000001);
         t = cyc_n;
         rd_chk("in window", WWD_OFS_FAULT_FLAGS, {30'h0, halted, 1'b0});
         while (cyc_n < t + 600) @(posedge clk);
         rd_chk("no early", WWD_OFS_FAULT_FLAGS, 32'h0);
         while (cyc_n < t + 700) @(posedge clk);
         rd_chk("underflow", WWD_OFS_FAULT_FLAGS, {31'h0, ~halted});
      end
      end_sim;
   end

   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      end_sim;
   end
endmodule // test_windowed_watchdog_timer
